// ===== verilog/sms_regs.svh
// register offsets, bit positions and reset values of the serial port
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH
`define SMS_OFS_STAT   2'h0
`define SMS_OFS_CON1   2'h1
`define SMS_OFS_BUF    2'h2
`define SMS_BIT_EN     15
`define SMS_BIT_SIDL   13
`define SMS_BIT_ROV    6
`define SMS_BIT_TBF    1
`define SMS_BIT_RBF    0
`define SMS_BIT_WORD_WIDTH_SELECT 10
`define SMS_RST_CON1   16'h0000
`define SMS_RST_PINS   3'h1
`define SMS_BITS_BYTE  5'h08
`define SMS_BITS_WORD  5'h10
`endif

// ===== verilog/sms_pkg.sv
// types of the serial port
package sms_pkg;
  typedef struct packed {
    logic [2:0] unused;
    logic       clock_pin_disable;
    logic       data_out_disable;
    logic       word_width_select;
    logic       sample_phase_bit;
    logic       clock_edge_bit;
    logic       slave_select_enable;
    logic       clock_polarity_bit;
    logic       master_enable_bit;
    logic [2:0] secondary_prescale_field;
    logic [1:0] primary_prescale_field;
  } sms_con1_t;
  typedef enum logic {
    SMS_IDLE  = 1'b0,
    SMS_SHIFT = 1'b1
  } sms_state_t;
endpackage

// ===== verilog/sms_port.sv
// serial port: register access, master and slave shift engine
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`include "sms_regs.svh"
module sms_port (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // device power state
  input  wire logic        device_idle,
  // serial pins
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  output logic             serial_data_out_pin,
  output logic             serial_data_out_pin_oe,
  input  wire logic        serial_data_in_pin,
  input  wire logic        slave_select_pin_n
);

  function automatic logic [9:0] div_ratio(input logic [1:0] pp, input logic [2:0] sp);
    logic [9:0] pri;
    pri = 10'h001 << {pp ^ 2'h3, 1'b0};
    div_ratio = pri * {6'h00, 4'h8 - {1'b0, sp}};
  endfunction

  function automatic logic msb_of(input logic [15:0] v, input logic m16);
    msb_of = m16 ? v[15] : v[7];
  endfunction

  // reset release
  logic [1:0] rst_pipe;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  wire rst_ok = rst_pipe[1];

  // state
  sms_pkg::sms_con1_t  con1_reg;
  sms_pkg::sms_state_t state_reg;
  logic        en_reg;
  logic        sidl_reg;
  logic        rov_reg;
  logic        tbf_reg;
  logic        rbf_reg;
  logic [15:0] txh_reg;
  logic [15:0] rxh_reg;
  logic [15:0] sr_reg;
  logic        out_bit_reg;
  logic [4:0]  bits_reg;
  logic [5:0]  tcnt_reg;
  logic [9:0]  div_reg;
  logic        act_reg;
  logic        sck_d_reg;
  logic [2:0]  pin_s1_reg;
  logic [2:0]  pin_s2_reg;

  // register decode
  wire acc_stat = reg_addr == `SMS_OFS_STAT;
  wire acc_con1 = reg_addr == `SMS_OFS_CON1;
  wire acc_buf  = reg_addr == `SMS_OFS_BUF;
  wire wr_stat  = reg_wr & acc_stat;
  wire wr_con1  = reg_wr & acc_con1;
  wire wr_buf   = reg_wr & acc_buf;
  wire rd_buf   = reg_rd & acc_buf;
  wire width_chg = wr_con1 & (reg_wdata[`SMS_BIT_WORD_WIDTH_SELECT] != con1_reg.word_width_select);
  wire halt      = sidl_reg & device_idle;
  wire go        = en_reg & ~halt & ~width_chg;
  wire is_master = con1_reg.master_enable_bit;
  wire cke       = con1_reg.clock_edge_bit;
  wire m16       = con1_reg.word_width_select;
  wire [15:0] stat_view = {en_reg, 1'b0, sidl_reg, 6'h00, rov_reg, 4'h0, tbf_reg, rbf_reg};
  wire [15:0] rd_mux = acc_stat ? stat_view :
                       acc_con1 ? con1_reg :
                       acc_buf  ? rxh_reg : 16'h0000;

  // master clock generation
  wire [4:0] word_bits = m16 ? `SMS_BITS_WORD : `SMS_BITS_BYTE;
  wire [9:0] prod      = div_ratio(con1_reg.primary_prescale_field,
                                   con1_reg.secondary_prescale_field);
  wire [9:0] half      = {1'b0, prod[9:1]};
  wire [9:0] prod_m1   = prod - 10'h001;
  wire [9:0] half_m1   = half - 10'h001;
  wire m_run  = (state_reg == sms_pkg::SMS_SHIFT) & is_master;
  wire tick   = m_run & ((div_reg == prod_m1) | (div_reg == half_m1));
  wire [5:0] n2      = {word_bits, 1'b0};
  wire m_edge = tick & (tcnt_reg < n2);
  wire m_lead = ~tcnt_reg[0];
  wire m_mid  = m_edge & (m_lead == cke);
  wire m_end  = tick & (tcnt_reg[0] == cke) & (tcnt_reg != 6'h00);
  wire m_smp  = con1_reg.sample_phase_bit ? m_end : m_mid;
  wire m_chg  = m_edge & (m_lead != cke);
  wire [5:0] m_last  = (cke | ~con1_reg.sample_phase_bit) ? n2 - 6'h01 : n2;
  wire m_done = tick & (tcnt_reg == m_last);

  // slave side, synchronised pins
  wire s_sck  = pin_s2_reg[2];
  wire din    = pin_s2_reg[1];
  wire ss_ok  = ~con1_reg.slave_select_enable | ~pin_s2_reg[0];
  wire s_edge = (s_sck ^ sck_d_reg) & ~is_master & ss_ok;
  wire s_lead = s_sck ^ con1_reg.clock_polarity_bit;
  wire s_smp  = s_edge & (s_lead == cke);
  wire s_chg  = s_edge & (s_lead != cke);

  // shift engine
  wire ev_smp = is_master ? m_smp : s_smp;
  wire ev_chg = is_master ? m_chg : s_chg;
  wire [15:0] sr_n   = ev_smp ? {sr_reg[14:0], din} : sr_reg;
  wire [4:0]  bits_n = bits_reg + {4'h0, ev_smp};
  wire done   = is_master ? m_done : (s_smp & (bits_n == word_bits));
  wire xfer_done = go & done;
  wire load   = go & tbf_reg & (is_master ? (state_reg == sms_pkg::SMS_IDLE)
                                          : ((bits_reg == 5'h00) & ~s_smp));
  wire desel  = ~is_master & ~ss_ok;

  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      pin_s1_reg <= `SMS_RST_PINS;
      pin_s2_reg <= `SMS_RST_PINS;
      sck_d_reg  <= 1'b0;
    end else if (clk_en) begin
      pin_s1_reg <= {serial_clock_pin_in, serial_data_in_pin, slave_select_pin_n};
      pin_s2_reg <= pin_s1_reg;
      sck_d_reg  <= pin_s2_reg[2];
    end
  end

  // software registers
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      en_reg   <= 1'b0;
      sidl_reg <= 1'b0;
      con1_reg <= `SMS_RST_CON1;
      txh_reg  <= 16'h0000;
    end else if (clk_en) begin
      if (wr_stat) begin
        en_reg   <= reg_wdata[`SMS_BIT_EN];
        sidl_reg <= reg_wdata[`SMS_BIT_SIDL];
      end
      if (wr_con1) begin
        con1_reg <= {3'h0, reg_wdata[12:0]};
        con1_reg.sample_phase_bit <= reg_wdata[9] & reg_wdata[5];
      end
      if (wr_buf)
        txh_reg <= reg_wdata;
    end
  end

  // status flags and receive holding
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      rov_reg <= 1'b0;
      tbf_reg <= 1'b0;
      rbf_reg <= 1'b0;
      rxh_reg <= 16'h0000;
    end else if (clk_en) begin
      if (width_chg) begin
        rov_reg <= 1'b0;
        tbf_reg <= 1'b0;
        rbf_reg <= 1'b0;
      end else begin
        if (xfer_done & rbf_reg)
          rov_reg <= 1'b1;
        else if (wr_stat & ~reg_wdata[`SMS_BIT_ROV])
          rov_reg <= 1'b0;
        if (wr_buf)
          tbf_reg <= 1'b1;
        else if (load)
          tbf_reg <= 1'b0;
        if (xfer_done & ~rbf_reg) begin
          rbf_reg <= 1'b1;
          rxh_reg <= sr_n;
        end else if (rd_buf)
          rbf_reg <= 1'b0;
      end
    end
  end

  // engine
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      state_reg   <= sms_pkg::SMS_IDLE;
      sr_reg      <= 16'h0000;
      out_bit_reg <= 1'b0;
      bits_reg    <= 5'h00;
      tcnt_reg    <= 6'h00;
      div_reg     <= 10'h000;
      act_reg     <= 1'b0;
    end else if (clk_en) begin
      if (~en_reg | width_chg | desel) begin
        state_reg <= sms_pkg::SMS_IDLE;
        bits_reg  <= 5'h00;
        tcnt_reg  <= 6'h00;
        div_reg   <= 10'h000;
        act_reg   <= 1'b0;
      end else if (~halt) begin
        if (load) begin
          sr_reg      <= txh_reg;
          out_bit_reg <= msb_of(txh_reg, m16);
          state_reg   <= sms_pkg::SMS_SHIFT;
          bits_reg    <= 5'h00;
          tcnt_reg    <= 6'h00;
          div_reg     <= 10'h000;
        end else begin
          sr_reg   <= sr_n;
          bits_reg <= done ? 5'h00 : bits_n;
          if (ev_chg)
            out_bit_reg <= msb_of(sr_n, m16);
          if (done)
            state_reg <= sms_pkg::SMS_IDLE;
          if (m_run) begin
            div_reg <= (div_reg == prod_m1) ? 10'h000 : div_reg + 10'h001;
            if (tick)
              tcnt_reg <= tcnt_reg + 6'h01;
            if (m_edge)
              act_reg <= ~act_reg;
          end
        end
      end
    end
  end

  // outputs
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      reg_rdata              <= 16'h0000;
      serial_clock_pin_out   <= 1'b0;
      serial_clock_pin_oe    <= 1'b0;
      serial_data_out_pin    <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
    end else if (clk_en) begin
      reg_rdata              <= reg_rd ? rd_mux : 16'h0000;
      serial_clock_pin_out   <= con1_reg.clock_polarity_bit ^ act_reg;
      serial_clock_pin_oe    <= en_reg & is_master & ~con1_reg.clock_pin_disable;
      serial_data_out_pin    <= out_bit_reg;
      serial_data_out_pin_oe <= en_reg & ~con1_reg.data_out_disable & (is_master | ss_ok);
    end
  end

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_ok);

  chk_rx_read_clear: assert property (
    (clk_en && rd_buf && !width_chg && !(xfer_done && !rbf_reg)) |=> !rbf_reg)
    else $error("receive-full not cleared by buffer read");

  chk_tx_write_set: assert property (
    (clk_en && wr_buf) |=> tbf_reg && txh_reg == $past(reg_wdata))
    else $error("transmit-full not set by buffer write");

  chk_ovf_keep: assert property (
    (clk_en && xfer_done && rbf_reg && !rd_buf) |=> rov_reg && $stable(rxh_reg))
    else $error("overflow word not discarded");

  chk_smp_slave: assert property (
    !con1_reg.master_enable_bit |-> !con1_reg.sample_phase_bit)
    else $error("sample phase set in slave mode");

  chk_sck_release: assert property (
    (clk_en && (!en_reg || !is_master || con1_reg.clock_pin_disable)) |=> !serial_clock_pin_oe)
    else $error("clock pin driven while released");

  chk_sdo_release: assert property (
    (clk_en && con1_reg.data_out_disable) |=> !serial_data_out_pin_oe)
    else $error("data pin driven while released");

  chk_idle_level: assert property (
    (clk_en && state_reg == sms_pkg::SMS_IDLE && !act_reg) |=>
      serial_clock_pin_out == $past(con1_reg.clock_polarity_bit))
    else $error("master clock not at idle level");

  chk_done_count: assert property (
    (clk_en && go && done && !is_master) |-> bits_n == word_bits)
    else $error("word ended at wrong bit count");

  chk_edge_count: assert property (
    (clk_en && go && m_done) |-> tcnt_reg >= n2 - 6'h01 && !(m_edge && act_reg == 1'b0))
    else $error("master ended with clock active");

  chk_sidl_halt: assert property (
    (clk_en && halt && !width_chg && en_reg && !desel) |=> $stable(sr_reg) && $stable(tcnt_reg))
    else $error("port moved while halted in idle");

  chk_width_reset: assert property (
    (clk_en && width_chg) |=> state_reg == sms_pkg::SMS_IDLE && bits_reg == 5'h00 && !tbf_reg)
    else $error("width change did not reset port");

endmodule

// ===== tb/sms_peer_model.sv
// serial partner answering the port while it is master
module sms_peer_model (
  // serial side
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  // bench side
  input  wire logic        load,
  input  wire logic [15:0] reply,
  output logic [15:0]      heard
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] out_sr;
  initial begin
    miso = 1'b0;
    heard = 16'h0000;
    out_sr = 16'h0000;
  end
  // new word armed; stale line level inverted
  always @(posedge load) begin
    out_sr = reply;
    miso = ~miso;
  end
  // data changes on leading edge, msb first
  always @(posedge sck) begin
    miso = out_sr[15];
    out_sr = {out_sr[14:0], 1'b0};
  end
  always @(negedge sck) heard = {heard[14:0], mosi};
endmodule

// ===== tb/sms_port_tb_top.sv
// self-checking bench of the serial port
module sms_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, reg_wr, reg_rd, device_idle;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd, peer_reply, heard;
  logic        sck_o, sck_oe, sdo, sdo_oe, tb_sck, tb_sdi, slave_mode, peer_load, miso, ss_n;
  int          errors, checked, n;
  sms_port DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .device_idle(device_idle),
    .serial_clock_pin_in(sck_oe ? sck_o : tb_sck), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe(sck_oe), .serial_data_out_pin(sdo), .serial_data_out_pin_oe(sdo_oe),
    .serial_data_in_pin(slave_mode ? tb_sdi : miso), .slave_select_pin_n(ss_n)
  );
  sms_peer_model peer (
    .sck(sck_o), .mosi(sdo), .miso(miso), .load(peer_load), .reply(peer_reply), .heard(heard)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic poll(input int b);
    for (int i = 0; i < 400; i++) begin
      rdr(2'h0);
      if (rd[b] === 1'b1) break;
    end
  endtask
  task automatic arm(input logic [15:0] r);
    peer_reply = r;
    peer_load = 1'b1;
    #1 peer_load = 1'b0;
  endtask
  task automatic test_regs();
    rdr(2'h0); check(rd, 16'h0000);
    rdr(2'h1); check(rd, 16'h0000);
    wr(2'h3, 16'hffff);
    rdr(2'h3); check(rd, 16'h0000);
    wr(2'h1, 16'hffff);
    rdr(2'h1); check(rd, 16'h1fff);
    wr(2'h1, 16'hffdf);
    rdr(2'h1); check(rd, 16'h1ddf);
    wr(2'h0, 16'hffff);
    rdr(2'h0); check(rd, 16'ha000);
    wr(2'h0, 16'h0000);
    $display("done: registers");
  endtask
  task automatic test_master();
    wr(2'h1, 16'h183d);
    wr(2'h0, 16'h8000);
    @(posedge ref_clk);
    #1 check({14'h0, sck_oe, sdo_oe}, 16'h0000);
    wr(2'h1, 16'h043d);
    @(posedge ref_clk);
    #1 check({14'h0, sck_oe, sdo_oe}, 16'h0003);
    arm(16'h5a3c);
    wr(2'h2, 16'hc3a5);
    rdr(2'h0); check(rd, 16'h8000);
    poll(0); check(rd, 16'h8001);
    check(heard, 16'hc3a5);
    $display("done: master word");
  endtask
  task automatic test_overflow();
    wr(2'h1, 16'h043e);
    wr(2'h0, 16'ha000);
    device_idle <= 1'b1;
    arm(16'h0ff0);
    wr(2'h2, 16'h1234);
    repeat (20) @(posedge ref_clk);
    rdr(2'h0); check(rd, 16'ha003);
    check({15'h0, sck_o}, 16'h0000);
    device_idle <= 1'b0;
    while (sck_o !== 1'b1) @(posedge ref_clk);
    n = 0;
    while (sck_o !== 1'b0) begin
      @(posedge ref_clk);
      n++;
    end
    while (sck_o !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    check(16'(n), 16'h0004);
    poll(6); check(rd, 16'ha041);
    rdr(2'h2); check(rd, 16'h5a3c);
    rdr(2'h0); check(rd, 16'ha040);
    wr(2'h0, 16'h8040);
    rdr(2'h0); check(rd, 16'h8040);
    wr(2'h0, 16'h8000);
    rdr(2'h0); check(rd, 16'h8000);
    $display("done: overflow and idle");
  endtask
  task automatic test_slave();
    logic [7:0] tx = 8'h3c;
    logic [7:0] rx = 8'h96;
    slave_mode = 1'b1;
    wr(2'h1, 16'h0000);
    wr(2'h2, 16'h003c);
    for (int i = 7; i >= 0; i--) begin
      #62.5 tb_sck = 1'b1;
      tb_sdi = rx[i];
      #60 check({14'h0, sdo_oe, sdo}, {14'h0, 1'b1, tx[i]});
      #2.5 tb_sck = 1'b0;
    end
    poll(0);
    rdr(2'h2); check({8'h00, rd[7:0]}, 16'h0096);
    // select pin now governs the data pin
    wr(2'h1, 16'h0080);
    repeat (2) @(posedge ref_clk);
    #1 check({15'h0, sdo_oe}, 16'h0001);
    @(posedge ref_clk);
    ss_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 check({15'h0, sdo_oe}, 16'h0000);
    @(posedge ref_clk);
    ss_n <= 1'b0;
    $display("done: slave byte");
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    device_idle = 1'b0;
    tb_sck = 1'b0;
    tb_sdi = 1'b0;
    slave_mode = 1'b0;
    peer_load = 1'b0;
    peer_reply = 16'h0000;
    ss_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_regs();
    test_master();
    test_overflow();
    test_slave();
    conclude();
  end
endmodule
